/* File: core/cmpc_control_regs.sv */
// Register block of the analog comparator: APB slave, control and ladder
// registers, edge flag and interrupt logic.
// Assumes the analog core, its input muxes and the ladder sit outside and
// take the selector outputs as static levels.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module cmpc_control_regs
    import cmpc_pkg::*;
#(
    parameter int ADDR_W = CMPC_ADDR_W
)
(
    input  wire logic                  clk_sys,          // System clock.
    input  wire logic                  reset_n,          // Sync reset, low.
    input  wire logic                  psel,             // APB select.
    input  wire logic                  penable,          // APB enable.
    input  wire logic                  pwrite,           // APB write.
    input  wire logic [ADDR_W-1:0]     paddr,            // APB byte address.
    input  wire logic [31:0]           pwdata,           // APB write data.
    input  wire logic [3:0]            pstrb,            // APB byte lanes.
    output logic      [31:0]           prdata,           // APB read data.
    output logic                       pready,           // APB ready.
    output logic                       pslverr,          // APB error.
    input  wire logic                  compRaw,          // Analog result.
    output logic                       compOut,          // Result to others.
    output cmpc_input_sel_t            plusSelect,       // Positive input.
    output cmpc_input_sel_t            minusSelect,      // Negative input.
    output logic      [HYST_W-1:0]     hysteresisSelect, // Hysteresis code.
    output logic                       ladderEnable,     // Ladder power.
    output logic      [LAD_STEP_W-1:0] ladderStep,       // Ladder step.
    output logic                       ladderRefSelect,  // Ladder reference.
    output logic                       irqOut            // Interrupt level.
);

    // Shared signals between synchroniser, detector and this block.
    cmpc_edge_if edgeBus ();

    cmpc_sync u_sync (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .compRaw (compRaw),
        .sb      (edgeBus.syncer)
    );

    cmpc_edge_det u_edge (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .eb      (edgeBus.detector)
    );

    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic [31:0] ladder_reg;
    logic [31:0] ladder_next;
    logic        edgeFlag_reg;
    logic        edgeFlag_next;
    logic        irqStatus_reg;
    logic        irqStatus_next;
    logic        irqMask_reg;
    logic        irqMask_next;
    logic        irq_reg;
    logic        irq_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pready_reg;
    logic        pready_next;
    logic        pslverr_reg;
    logic        pslverr_next;

    logic [31:0] laneMask;
    logic        setupPhase;
    logic        accessDone;
    logic        hitCtrl;
    logic        hitLadder;
    logic        hitStatus;
    logic        hitMask;
    logic        addrHit;
    logic        clearRise;
    logic        edgePulse;
    logic [31:0] ctrlView;

    // Byte-lane mask built from the strobes.
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            laneMask[i*8 +: 8] = {8{pstrb[i]}};
        end
    end

    // Address decode and bus phases.
    always_comb
    begin
        setupPhase = psel & ~penable;
        accessDone = psel & penable & pready_reg;
        hitCtrl    = (paddr == CTRL_OFFSET);
        hitLadder  = (paddr == LADDER_OFFSET);
        hitStatus  = (paddr == IRQ_STATUS_OFFSET);
        hitMask    = (paddr == IRQ_MASK_OFFSET);
        addrHit    = hitCtrl | hitLadder | hitStatus | hitMask;
        edgePulse  = edgeBus.edgePulse;
    end

    // Read view of the control register: stored bits plus live status.
    always_comb
    begin
        ctrlView             = ctrl_reg;
        ctrlView[RESULT_BIT] = edgeBus.syncLevel;
        ctrlView[FLAG_BIT]   = edgeFlag_reg;
    end

    // Next state of every register and of the bus answer. A write lands
    // only at the access edge where pready is high. A detected edge in the
    // same cycle as a clear wins, so no event is lost.
    always_comb
    begin
        ctrl_next      = ctrl_reg;
        ladder_next    = ladder_reg;
        irqMask_next   = irqMask_reg;
        irqStatus_next = irqStatus_reg;
        edgeFlag_next  = edgeFlag_reg;
        clearRise      = 1'b0;

        if (accessDone && pwrite && hitCtrl)
        begin
            ctrl_next = (ctrl_reg & ~(laneMask & CTRL_WRITE_MASK))
                      | (pwdata & laneMask & CTRL_WRITE_MASK);
            // Clearing on the rising write keeps the one-then-zero habit
            // harmless: the following zero write has no effect.
            clearRise = ctrl_next[CLEAR_BIT] & ~ctrl_reg[CLEAR_BIT];
        end
        if (accessDone && pwrite && hitLadder)
        begin
            ladder_next = (ladder_reg & ~(laneMask & LADDER_WRITE_MASK))
                        | (pwdata & laneMask & LADDER_WRITE_MASK);
        end
        if (accessDone && pwrite && hitMask && pstrb[0])
        begin
            irqMask_next = pwdata[0];
        end
        if (accessDone && pwrite && hitStatus && pstrb[0] && pwdata[0])
        begin
            irqStatus_next = 1'b0;
        end
        if (clearRise)
        begin
            edgeFlag_next  = 1'b0;
            irqStatus_next = 1'b0;
        end
        if (edgePulse)
        begin
            edgeFlag_next  = 1'b1;
            irqStatus_next = 1'b1;
        end
        irq_next = irqStatus_next & irqMask_next;

        // Answer is prepared in the setup cycle, giving zero wait states.
        pready_next  = setupPhase;
        pslverr_next = setupPhase & ~addrHit;
        prdata_next  = 32'h0000_0000;
        if (setupPhase && !pwrite)
        begin
            case (1'b1)
                hitCtrl:   prdata_next = ctrlView;
                hitLadder: prdata_next = ladder_reg;
                hitStatus: prdata_next = {31'h0000_0000, irqStatus_reg};
                hitMask:   prdata_next = {31'h0000_0000, irqMask_reg};
                default:   prdata_next = 32'h0000_0000;
            endcase
        end
    end

    // Registers only; everything clears on reset except the mask.
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            ctrl_reg      <= CTRL_RESET;
            ladder_reg    <= LADDER_RESET;
            edgeFlag_reg  <= 1'b0;
            irqStatus_reg <= 1'b0;
            irqMask_reg   <= IRQ_MASK_RESET;
            irq_reg       <= 1'b0;
            prdata_reg    <= 32'h0000_0000;
            pready_reg    <= 1'b0;
            pslverr_reg   <= 1'b0;
        end
        else
        begin
            ctrl_reg      <= ctrl_next;
            ladder_reg    <= ladder_next;
            edgeFlag_reg  <= edgeFlag_next;
            irqStatus_reg <= irqStatus_next;
            irqMask_reg   <= irqMask_next;
            irq_reg       <= irq_next;
            prdata_reg    <= prdata_next;
            pready_reg    <= pready_next;
            pslverr_reg   <= pslverr_next;
        end
    end

    // Outputs straight from the stored fields.
    assign edgeBus.edgeSelect = ctrl_reg[EDGE_SEL_LSB +: EDGE_SEL_W];
    assign plusSelect       = ctrl_reg[PLUS_SEL_LSB +: INPUT_SEL_W];
    assign minusSelect      = ctrl_reg[MINUS_SEL_LSB +: INPUT_SEL_W];
    assign hysteresisSelect = ctrl_reg[HYST_LSB +: HYST_W];
    assign ladderEnable     = ladder_reg[LAD_EN_BIT];
    assign ladderStep       = ladder_reg[LAD_STEP_LSB +: LAD_STEP_W];
    assign ladderRefSelect  = ladder_reg[LAD_REF_BIT];
    assign irqOut           = irq_reg;
    assign prdata           = prdata_reg;
    assign pready           = pready_reg;
    assign pslverr          = pslverr_reg;

    // The raw path must stay unclocked so it works with the bus clock off;
    // the synchronised path costs two cycles of latency.
    assign compOut = ctrl_reg[SYNC_SEL_BIT] ? edgeBus.syncLevel
                                            : compRaw;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    sequence ctrl_write_done;
        psel && penable && pready && pwrite && hitCtrl && (pstrb == 4'hF);
    endsequence

    sequence ctrl_read_done;
        psel && penable && pready && !pwrite && hitCtrl;
    endsequence

    edge_sets_flag_a: assert property (
        edgePulse |=> edgeFlag_reg)
        else $error("Selected edge did not set the edge flag.");

    sync_path_a: assert property (
        (ctrl_reg[SYNC_SEL_BIT] && $past(reset_n, 1) && $past(reset_n, 2))
        |-> (compOut == $past(compRaw, 2)))
        else $error("Synchronised output path not selected.");

    plus_sel_a: assert property (
        ctrl_write_done |=> (plusSelect == $past(pwdata[10:8])))
        else $error("Positive input selection not stored.");

    minus_sel_a: assert property (
        ctrl_write_done |=> (minusSelect == $past(pwdata[13:11])))
        else $error("Negative input selection not stored.");

    clear_flag_a: assert property (
        (clearRise && !edgePulse) |=> (!edgeFlag_reg && !irqOut))
        else $error("Clear bit did not clear flag and interrupt.");

    result_read_a: assert property (
        ctrl_read_done |-> (prdata[RESULT_BIT] == $past(edgeBus.syncLevel)))
        else $error("Result bit does not show the comparator state.");

    hyst_store_a: assert property (
        ctrl_write_done |=> (hysteresisSelect == $past(pwdata[26:25])))
        else $error("Hysteresis code not stored.");

    unmapped_err_a: assert property (
        (setupPhase && !addrHit) |=> (pready && pslverr))
        else $error("Unmapped address not answered with an error.");

    irq_raise_a: assert property (
        (edgePulse && irqMask_reg && !(accessDone && hitMask && pwrite))
        |=> irqOut)
        else $error("Edge did not raise the interrupt.");

    ladder_store_a: assert property (
        (psel && penable && pready && pwrite && hitLadder && pstrb[0])
        |=> ({ladderRefSelect, ladderStep, ladderEnable}
             == $past(pwdata[6:0])))
        else $error("Ladder fields not stored.");

    // The flag must stand until software clears it.
    flag_hold_a: assert property (
        (edgeFlag_reg && !clearRise) |=> edgeFlag_reg)
        else $error("Edge flag dropped without a clear.");

    // The answer stands for exactly one access cycle.
    ready_pulse_a: assert property (
        pready |=> !pready)
        else $error("Bus answer stood for more than one cycle.");

endmodule : cmpc_control_regs
`default_nettype wire

/* File: core/cmpc_pkg.sv */
// Constants shared by the comparator control logic: register offsets,
// field positions, writable masks, reset values and selector encodings.
// Assumes a 32-bit APB register bus with byte addresses.
package cmpc_pkg;

    // Bus geometry.
    localparam int          CMPC_ADDR_W   = 12;
    localparam int          CMPC_DATA_W   = 32;

    // Register byte offsets from the block base.
    localparam logic [11:0] CTRL_OFFSET       = 12'h000;
    localparam logic [11:0] LADDER_OFFSET     = 12'h004;
    localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h008;
    localparam logic [11:0] IRQ_MASK_OFFSET   = 12'h00C;

    // Fields of comparator_control.
    localparam int EDGE_SEL_LSB  = 3;
    localparam int EDGE_SEL_W    = 2;
    localparam int SYNC_SEL_BIT  = 6;
    localparam int PLUS_SEL_LSB  = 8;
    localparam int MINUS_SEL_LSB = 11;
    localparam int INPUT_SEL_W   = 3;
    localparam int CLEAR_BIT     = 20;
    localparam int RESULT_BIT    = 21;
    localparam int FLAG_BIT      = 23;
    localparam int HYST_LSB      = 25;
    localparam int HYST_W        = 2;

    // Fields of ladder_setting.
    localparam int LAD_EN_BIT    = 0;
    localparam int LAD_STEP_LSB  = 1;
    localparam int LAD_STEP_W    = 5;
    localparam int LAD_REF_BIT   = 6;

    // Bits that software may store; everything else reads as zero or status.
    localparam logic [31:0] CTRL_WRITE_MASK   = 32'h0610_3F58;
    localparam logic [31:0] LADDER_WRITE_MASK = 32'h0000_007F;
    localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;
    localparam logic [31:0] LADDER_RESET      = 32'h0000_0000;
    localparam logic        IRQ_MASK_RESET    = 1'b1;

    // Edge selection codes; the two remaining codes both mean both edges.
    typedef logic [EDGE_SEL_W-1:0] cmpc_edge_sel_t;
    localparam cmpc_edge_sel_t EDGE_FALLING = 2'h0;
    localparam cmpc_edge_sel_t EDGE_RISING  = 2'h1;

    // Comparator input selection codes; other codes are reserved.
    typedef logic [INPUT_SEL_W-1:0] cmpc_input_sel_t;
    localparam cmpc_input_sel_t INPUT_LADDER  = 3'h0;
    localparam cmpc_input_sel_t INPUT_EXT_ONE = 3'h1;
    localparam cmpc_input_sel_t INPUT_EXT_TWO = 3'h2;
    localparam cmpc_input_sel_t INPUT_BANDGAP = 3'h6;

endpackage : cmpc_pkg

/* File: core/cmpc_edge_if.sv */
// Carrier between the synchroniser, the edge detector and the register
// block. All three sit on clk_sys.
`timescale 1ns/100ps
`default_nettype none
interface cmpc_edge_if;
    import cmpc_pkg::*;

    logic           syncLevel;  // Synchronised comparator result.
    cmpc_edge_sel_t edgeSelect; // Edge selection from the control register.
    logic           edgePulse;  // One-cycle pulse on a selected edge.

    modport syncer   (output syncLevel);
    modport detector (input syncLevel, input edgeSelect, output edgePulse);
endinterface : cmpc_edge_if
`default_nettype wire

/* File: core/cmpc_sync.sv */
// Two-flop synchroniser for the raw analog comparator result.
// Assumes compRaw may change at any time relative to clk_sys.
`timescale 1ns/100ps
`default_nettype none
module cmpc_sync
    import cmpc_pkg::*;
(
    input  wire logic     clk_sys, // System clock.
    input  wire logic     reset_n, // Synchronous reset, active low.
    input  wire logic     compRaw, // Raw comparator result.
    cmpc_edge_if.syncer   sb       // Synchronised level out.
);

    logic syncFirst_reg;
    logic syncFirst_next;
    logic syncLevel_reg;
    logic syncLevel_next;

    // Only the second flop is ever read, so metastability stays contained.
    always_comb
    begin
        syncFirst_next = compRaw;
        syncLevel_next = syncFirst_reg;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            syncFirst_reg <= 1'b0;
            syncLevel_reg <= 1'b0;
        end
        else
        begin
            syncFirst_reg <= syncFirst_next;
            syncLevel_reg <= syncLevel_next;
        end
    end

    assign sb.syncLevel = syncLevel_reg;

    sync_delay_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        ($past(reset_n, 1) && $past(reset_n, 2))
        |-> (syncLevel_reg == $past(compRaw, 2)))
        else $error("Synchronised result is not two cycles behind.");

endmodule : cmpc_sync
`default_nettype wire

/* File: core/cmpc_edge_det.sv */
// Edge detector on the synchronised comparator result.
// Assumes its input comes from the synchroniser on the same clock.
`timescale 1ns/100ps
`default_nettype none
module cmpc_edge_det
    import cmpc_pkg::*;
(
    input  wire logic     clk_sys, // System clock.
    input  wire logic     reset_n, // Synchronous reset, active low.
    cmpc_edge_if.detector eb       // Level in, selection in, pulse out.
);

    logic prevLevel_reg;
    logic prevLevel_next;
    logic rose;
    logic fell;

    // Compare each sample with the previous one and filter by selection.
    always_comb
    begin
        prevLevel_next = eb.syncLevel;
        rose           = eb.syncLevel & ~prevLevel_reg;
        fell           = ~eb.syncLevel & prevLevel_reg;
        case (eb.edgeSelect)
            EDGE_FALLING: eb.edgePulse = fell;
            EDGE_RISING:  eb.edgePulse = rose;
            default:      eb.edgePulse = rose | fell;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            prevLevel_reg <= 1'b0;
        else
            prevLevel_reg <= prevLevel_next;
    end

    sequence rise_seen;
        (eb.edgeSelect == EDGE_RISING) ##0 $rose(eb.syncLevel);
    endsequence

    rise_pulse_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        rise_seen |-> eb.edgePulse)
        else $error("Rising edge did not pulse in rising mode.");

    fall_ignored_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (eb.edgeSelect == EDGE_RISING && $fell(eb.syncLevel))
        |-> !eb.edgePulse)
        else $error("Falling edge pulsed in rising mode.");

endmodule : cmpc_edge_det
`default_nettype wire

/* File: dv/cmpc_analog_model.sv */
// Behavioural model of the analog comparator core for the bench.
// Assumes the bench commands the comparison outcome directly.
`timescale 1ns/100ps
`default_nettype none
module cmpc_analog_model
(
    input  wire logic cmdLevel, // Commanded comparison outcome.
    output logic      compRaw   // Result towards the register block.
);
    // Start low so the block never sees an unknown result.
    initial
    begin
        compRaw = 1'b0;
    end

    // A short settling lag keeps the result off the clock edge, so it
    // reaches the synchroniser as an asynchronous level would.
    always @(cmdLevel)
    begin
        compRaw <= #3 cmdLevel;
    end
endmodule : cmpc_analog_model
`default_nettype wire

/* File: dv/tb_comparator_control_regs.sv */
// Self-checking bench for the comparator register block.
// Assumes a 50 MHz clock, zero-wait APB and the analog core model.
`timescale 1ns/100ps
`default_nettype none
module tb_comparator_control_regs
    import cmpc_pkg::*;
();
    typedef struct {
        logic [11:0] addr;
        logic [31:0] wd;
        logic [31:0] rd;
        logic        err;
    } cmpc_row_t;

    logic                  clk_sys = 1'b0;
    logic                  reset_n = 1'b0;
    logic                  psel = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite = 1'b0;
    logic [11:0]           paddr = 12'h000;
    logic [31:0]           pwdata = 32'h0000_0000;
    logic [3:0]            pstrb = 4'hF;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  cmdLevel = 1'b0;
    logic                  compRaw;
    logic                  compOut;
    cmpc_input_sel_t       plusSelect;
    cmpc_input_sel_t       minusSelect;
    logic [HYST_W-1:0]     hysteresisSelect;
    logic                  ladderEnable;
    logic [LAD_STEP_W-1:0] ladderStep;
    logic                  ladderRefSelect;
    logic                  irqOut;
    logic [31:0]           rdData;
    logic                  rdErr;
    int                    errorCnt = 0;
    int                    testsRun = 0;
    int                    m;

    // Each row is written, read back and compared with its expectation.
    cmpc_row_t rows [10] = '{
        '{12'h000, 32'h0200_3108, 32'h0200_3108, 1'b0},
        '{12'h000, 32'h0400_1250, 32'h0400_1250, 1'b0},
        '{12'h000, 32'h0600_0E18, 32'h0600_0E18, 1'b0},
        '{12'h000, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{12'h000, 32'h00A0_0000, 32'h0000_0000, 1'b0},
        '{12'h004, 32'hFFFF_FFFF, 32'h0000_007F, 1'b0},
        '{12'h004, 32'h0000_0040, 32'h0000_0040, 1'b0},
        '{12'h004, 32'h0000_003F, 32'h0000_003F, 1'b0},
        '{12'h010, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1},
        '{12'hFFC, 32'h1234_5678, 32'h0000_0000, 1'b1}};

    always
    begin
        #10 clk_sys = ~clk_sys;
    end

    cmpc_analog_model core (.cmdLevel(cmdLevel), .compRaw(compRaw));

    cmpc_control_regs uut (
        .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .compRaw(compRaw),
        .compOut(compOut), .plusSelect(plusSelect),
        .minusSelect(minusSelect), .hysteresisSelect(hysteresisSelect),
        .ladderEnable(ladderEnable), .ladderStep(ladderStep),
        .ladderRefSelect(ladderRefSelect), .irqOut(irqOut));

    task automatic wrapUp();
    begin
        $display("Checks %0d, mismatches %0d", testsRun, errorCnt);
        if (errorCnt == 0 && testsRun > 0)
        begin
            $display("Regression OK");
        end
        else
        begin
            $display("Regression broken");
        end
        $finish;
    end
    endtask : wrapUp

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        testsRun++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask : chk

    // One APB transfer; entered just after a rising edge. A spare edge at
    // the end keeps two transfers from driving psel twice in one step.
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        bit timedOut;
    begin
        n = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        timedOut = (pready !== 1'b1);
        rdData = prdata;
        rdErr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
        if (timedOut)
        begin
            errorCnt++;
            wrapUp();
        end
    end
    endtask : apb

    // Waits up to eight edges; an expected rise ends the wait early.
    task automatic waitIrq(input logic exp);
        int n;
    begin
        for (n = 0; n < 8; n++)
        begin
            @(posedge clk_sys);
            if (exp && irqOut === 1'b1)
            begin
                break;
            end
        end
    end
    endtask : waitIrq

    task automatic clearEdge(input int e);
    begin
        apb(1'b1, 12'h000, 32'h0010_0000 | (e << 3));
        apb(1'b1, 12'h000, e << 3);
    end
    endtask : clearEdge

    task automatic chkReset();
    begin
        chk({irqOut, ladderRefSelect, ladderStep, ladderEnable,
             hysteresisSelect, minusSelect, plusSelect}, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk(rdData, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rdData, 32'h0);
        apb(1'b0, 12'h00C, 32'h0);
        chk(rdData, 32'h1);
    end
    endtask : chkReset

    // Main sequence; reset is held for two clock cycles.
    initial
    begin
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        chkReset();
        $display("Test reset done");
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].addr, rows[i].wd);
            apb(1'b0, rows[i].addr, 32'h0);
            chk(rdData, rows[i].rd);
            chk(rdErr, rows[i].err);
            if (rows[i].addr == 12'h000)
            begin
                chk(plusSelect, rows[i].rd[10:8]);
                chk(minusSelect, rows[i].rd[13:11]);
                chk(hysteresisSelect, rows[i].rd[26:25]);
            end
            if (rows[i].addr == 12'h004)
            begin
                chk(ladderEnable, rows[i].rd[0]);
                chk(ladderStep, rows[i].rd[5:1]);
                chk(ladderRefSelect, rows[i].rd[6]);
            end
        end
        // A lane whose strobe is low keeps its old contents.
        pstrb <= 4'hE;
        apb(1'b1, 12'h004, 32'h0000_0040);
        pstrb <= 4'hF;
        apb(1'b0, 12'h004, 32'h0);
        chk(rdData, 32'h0000_003F);
        $display("Test rows done");
        // Every edge mode sees one rise and one fall of the result.
        for (m = 0; m < 4; m++)
        begin
            apb(1'b1, 12'h000, m << 3);
            cmdLevel <= 1'b1;
            waitIrq(m != 0);
            chk(irqOut, m != 0);
            apb(1'b0, 12'h000, 32'h0);
            chk(rdData[23:21], {m != 0, 2'b01});
            clearEdge(m);
            chk(irqOut, 1'b0);
            cmdLevel <= 1'b0;
            waitIrq(m != 1);
            chk(irqOut, m != 1);
            apb(1'b0, 12'h000, 32'h0);
            chk(rdData[23:21], {m != 1, 2'b00});
            clearEdge(m);
        end
        $display("Test edges done");
        // A masked edge stays pending in status until unmasked.
        apb(1'b1, 12'h00C, 32'h0);
        apb(1'b1, 12'h000, 32'h0000_0008);
        cmdLevel <= 1'b1;
        waitIrq(1'b0);
        chk(irqOut, 1'b0);
        apb(1'b0, 12'h008, 32'h0);
        chk(rdData, 32'h1);
        apb(1'b1, 12'h00C, 32'h1);
        @(posedge clk_sys);
        chk(irqOut, 1'b1);
        apb(1'b1, 12'h008, 32'h1);
        @(posedge clk_sys);
        chk(irqOut, 1'b0);
        clearEdge(1);
        $display("Test mask done");
        // Raw path shows a change at once; the synchronised path lags.
        cmdLevel <= 1'b0;
        @(negedge clk_sys);
        chk(compOut, 1'b0);
        @(posedge clk_sys);
        apb(1'b1, 12'h000, 32'h0000_0040);
        cmdLevel <= 1'b1;
        @(negedge clk_sys);
        chk(compOut, 1'b0);
        repeat (4) @(posedge clk_sys);
        chk(compOut, 1'b1);
        $display("Test output path done");
        // A second reset in mid-run clears every stored field except the mask, which returns to one.
        apb(1'b1, 12'h004, 32'h0000_007F);
        // The result goes low with reset so the status bit reads zero after.
        reset_n  <= 1'b0;
        cmdLevel <= 1'b0;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        chkReset();
        $display("Test second reset done");
        wrapUp();
    end
endmodule : tb_comparator_control_regs
`default_nettype wire
